// ---- src/fifo_level_counter.sv ----
// Occupancy counter that tracks characters entering and leaving one FIFO
`timescale 1ns/1ps
module fifo_level_counter #(
   parameter int DEPTH = uart_fifo_pkg::FIFO_DEPTH,
   parameter int W     = uart_fifo_pkg::LEVEL_W
) (
   // Clock and reset
   input  wire logic                     clk_in,
   input  wire logic                     resetn_in,
   // Character movement
   input  wire uart_fifo_pkg::fifo_move_t move_in,
   // Current occupancy
   output logic [W-1:0]                  level_out
);

   localparam logic [W-1:0] FULL = W'(DEPTH);
   localparam logic [W-1:0] ONE  = W'(1);

   // ============================================================
   // Count update; a push into a full FIFO or a pop from an empty
   // one is dropped so the count never leaves 0..DEPTH
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         level_out <= uart_fifo_pkg::LEVEL_RESET; // [R8]
      end else if (move_in.push && !move_in.pop &&
                   level_out < FULL) begin
         level_out <= level_out + ONE; // [R8]
      end else if (move_in.pop && !move_in.push &&
                   level_out != '0) begin
         level_out <= level_out - ONE; // [R8]
      end
   end

endmodule

// ---- src/modem_line_tracker.sv ----
// Modem line levels with sticky change bits for one channel
`timescale 1ns/1ps
module modem_line_tracker #(
   parameter int W = uart_fifo_pkg::MODEM_W
) (
   // Clock and reset
   input  wire logic           clk_in,
   input  wire logic           resetn_in,
   // Modem pins, asynchronous
   input  wire logic [W-1:0]   lines_in,
   // Clear of change bits on a read
   input  wire logic           clear_in,
   // Status: levels high, change bits low
   output logic [2*W-1:0]      state_out,
   output logic                change_out
);

   logic [W-1:0] sync_a;
   logic [W-1:0] sync_b;
   logic [2:0]   fill;
   logic [W-1:0] next_delta;
   logic [W-1:0] changed;

   // ============================================================
   // Two-stage synchroniser; only sync_b is looked at
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= lines_in;
         sync_b <= sync_a;
      end
   end

   // Change detection waits three edges after release: two for the
   // synchroniser to show the pins, one for the level field to
   // catch them; earlier, the reset zeros would look like changes
   assign changed = fill[2] ? (sync_b ^ state_out[2*W-1:W]) : '0;
   // Set wins over the read clear
   assign next_delta = (clear_in ? '0 : state_out[W-1:0]) | changed;

   // ============================================================
   // Levels are caught after release, since the async reset may
   // only load constants; change bits start clear
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fill       <= '0;
         state_out  <= {W'(0), uart_fifo_pkg::DELTA_RESET}; // [R7]
         change_out <= 1'b0;
      end else begin
         fill       <= {fill[1:0], 1'b1};
         change_out <= |changed;
         state_out  <= {sync_b, next_delta}; // [R7]
      end
   end

endmodule

// ---- src/uart_fifo_level_trigger.sv ----
// FIFO occupancy, trigger levels and interrupts behind a Wishbone slave
`timescale 1ns/1ps
module uart_fifo_level_trigger #(
   parameter int NUM_CH = 2,
   parameter int DEPTH  = uart_fifo_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    resetn_in,
   // Wishbone slave
   input  wire logic                    wb_cyc_in,
   input  wire logic                    wb_stb_in,
   input  wire logic                    wb_we_in,
   input  wire logic [7:0]              wb_adr_in,
   input  wire logic [3:0]              wb_sel_in,
   input  wire logic [31:0]             wb_dat_in,
   output logic [31:0]                  wb_dat_out,
   output logic                         wb_ack_out,
   // FIFO movement strobes from the UART cores
   input  wire logic [NUM_CH-1:0]       tx_push_in,
   input  wire logic [NUM_CH-1:0]       tx_pop_in,
   input  wire logic [NUM_CH-1:0]       rx_push_in,
   input  wire logic [NUM_CH-1:0]       rx_pop_in,
   // Modem input pins, four per channel
   input  wire logic [4*NUM_CH-1:0]     modem_in,
   // Trigger levels and interrupt
   output logic [NUM_CH-1:0]            tx_trigger_out,
   output logic [NUM_CH-1:0]            rx_trigger_out,
   output logic                         irq_out
);

   localparam int LW   = uart_fifo_pkg::LEVEL_W;
   localparam int MW   = uart_fifo_pkg::MODEM_W;
   localparam int IW   = uart_fifo_pkg::IRQ_PER_CH * NUM_CH;
   localparam int DW   = uart_fifo_pkg::DATA_W;

   // ============================================================
   // Register map, per channel c at base c*0x20:
   //   +0x00  transmit occupancy, read only, 0 to DEPTH
   //   +0x04  transmit trigger level, write only, reads as zero
   //   +0x08  receive occupancy, read only, 0 to DEPTH
   //   +0x0c  receive trigger level, write only, reads as zero
   //   +0x10  modem lines: levels in 7:4, change bits in 3:0
   // Shared registers:
   //   0x40   interrupt status, cleared by the read that shows it
   //   0x44   interrupt mask, same layout as the status
   //   0x48   trigger view: tx triggers low, rx triggers above
   // Status layout per channel c, three bits from bit 3c:
   //   +0     transmit level dropped below its trigger level
   //   +1     receive level climbed to its trigger level
   //   +2     a modem line changed in either direction
   // Level registers carry eight bits in lane 0; upper data bits
   // read as zero and are ignored on writes.
   // Trigger levels above DEPTH are kept as written: a transmit
   // trigger then holds even with a full FIFO, and a receive
   // trigger can never be reached. Software should keep to
   // 0..DEPTH.
   // After reset every count and level is zero, so each receive
   // trigger holds at once and raises its status bit on the
   // first edge; software should program levels, then read the
   // status once before it unmasks anything.

   // ============================================================
   // Bus request bundle and per-channel state
   uart_fifo_pkg::wb_req_t req;
   logic                   access;
   logic                   rd_access;
   logic                   wr_access;

   logic [LW-1:0]     tx_occ   [NUM_CH];
   logic [LW-1:0]     rx_occ   [NUM_CH];
   logic [LW-1:0]     tx_thr   [NUM_CH];
   logic [LW-1:0]     rx_thr   [NUM_CH];
   logic [2*MW-1:0]   modem    [NUM_CH];
   logic [NUM_CH-1:0] modem_chg;
   logic [NUM_CH-1:0] modem_rd;
   logic [NUM_CH-1:0] tx_thr_wr;
   logic [NUM_CH-1:0] rx_thr_wr;
   logic [NUM_CH-1:0] tx_low;
   logic [NUM_CH-1:0] rx_hit;

   // Interrupt state, three bits per channel
   logic [IW-1:0]     irq_stat;
   logic [IW-1:0]     irq_mask;
   logic [IW-1:0]     irq_set;
   logic [IW-1:0]     next_irq_stat;
   logic              stat_rd;
   logic              mask_wr;
   logic [DW-1:0]     next_rdata;

   assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in,
                  adr: wb_adr_in, sel: wb_sel_in, dat: wb_dat_in};

   // ============================================================
   // Bus handshake
   // Ack one cycle after the strobe, never two in a row, so a
   // master that holds its strobe sees a fresh access each time.
   // Writes act at the edge where ack is high, which is the edge
   // the master samples, so each write lands exactly once.
   // Reads are taken one edge earlier, when the request is first
   // seen: the data is captured and any read-clear acts at that
   // same edge, so an event arriving while ack stands is kept
   // for the next read instead of being cleared unseen
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= req.cyc && req.stb && !wb_ack_out;
      end
   end

   assign access    = req.cyc && req.stb && wb_ack_out;
   assign rd_access = req.cyc && req.stb && !wb_ack_out && !req.we;
   // Registers are at most eight bits wide, so only lane 0 carries a write
   assign wr_access = access && req.we && req.sel[0];

   // ============================================================
   // Per-channel counters, thresholds, triggers and modem state
   // Channel bases step by 0x20 and the shared registers start at
   // 0x40, so more than two channels would need a new map
   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_ch
         localparam logic [7:0] BASE = 8'(c * 32'(uart_fifo_pkg::CH_STRIDE));

         // Strobe decode for this channel
         assign tx_thr_wr[c] = wr_access &&
                               req.adr == BASE + uart_fifo_pkg::REG_TX_THR;
         assign rx_thr_wr[c] = wr_access &&
                               req.adr == BASE + uart_fifo_pkg::REG_RX_THR;
         assign modem_rd[c]  = rd_access &&
                               req.adr == BASE + uart_fifo_pkg::REG_MODEM;

         // Transmit occupancy
         fifo_level_counter #(
            .DEPTH (DEPTH),
            .W     (LW)
         ) u_tx_cnt (
            .clk_in    (clk_in),
            .resetn_in (resetn_in),
            .move_in   ('{push: tx_push_in[c], pop: tx_pop_in[c]}),
            .level_out (tx_occ[c])
         ); // [R1]

         // Receive occupancy
         fifo_level_counter #(
            .DEPTH (DEPTH),
            .W     (LW)
         ) u_rx_cnt (
            .clk_in    (clk_in),
            .resetn_in (resetn_in),
            .move_in   ('{push: rx_push_in[c], pop: rx_pop_in[c]}),
            .level_out (rx_occ[c])
         ); // [R4]

         // Modem line levels and change bits
         // Pins are synchronised inside; change bits clear on read
         modem_line_tracker #(
            .W (MW)
         ) u_modem (
            .clk_in     (clk_in),
            .resetn_in  (resetn_in),
            .lines_in   (modem_in[c*MW +: MW]),
            .clear_in   (modem_rd[c]),
            .state_out  (modem[c]),
            .change_out (modem_chg[c])
         );

         // Transmit trigger level; values above 64 kept as written
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               tx_thr[c] <= uart_fifo_pkg::LEVEL_RESET;
            end else if (tx_thr_wr[c]) begin
               tx_thr[c] <= req.dat[LW-1:0]; // [R2]
            end
         end

         // Receive trigger level; values above 64 kept as written
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               rx_thr[c] <= uart_fifo_pkg::LEVEL_RESET;
            end else if (rx_thr_wr[c]) begin
               rx_thr[c] <= req.dat[LW-1:0]; // [R5]
            end
         end

         // Trigger conditions; a receive level of zero always holds
         assign tx_low[c] = tx_occ[c] < tx_thr[c]; // [R3]
         assign rx_hit[c] = rx_occ[c] >= rx_thr[c]; // [R6]

         // Registered transmit trigger, also used for edge detection
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               tx_trigger_out[c] <= 1'b0;
            end else begin
               tx_trigger_out[c] <= tx_low[c]; // [R3]
            end
         end

         // Registered receive trigger, also used for edge detection
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               rx_trigger_out[c] <= 1'b0;
            end else begin
               rx_trigger_out[c] <= rx_hit[c]; // [R6]
            end
         end

         // Events: a trigger becoming true, or any modem change
         // The edge is found against the registered output, so a
         // condition already true after reset raises one event
         assign irq_set[c*uart_fifo_pkg::IRQ_PER_CH +
                        uart_fifo_pkg::IRQ_TX_BIT] =
            tx_low[c] && !tx_trigger_out[c]; // [R3]
         assign irq_set[c*uart_fifo_pkg::IRQ_PER_CH +
                        uart_fifo_pkg::IRQ_RX_BIT] =
            rx_hit[c] && !rx_trigger_out[c]; // [R6]
         assign irq_set[c*uart_fifo_pkg::IRQ_PER_CH +
                        uart_fifo_pkg::IRQ_MODEM_BIT] = modem_chg[c];
      end
   endgenerate

   // ============================================================
   // Interrupt status, mask and output
   assign stat_rd = rd_access && req.adr == uart_fifo_pkg::REG_IRQ_STAT;
   assign mask_wr = wr_access && req.adr == uart_fifo_pkg::REG_IRQ_MASK;

   // A read clears the status, but an event in the same cycle wins.
   // Bits are sticky: software sees every event once even when the
   // trigger condition has already gone away again by the read
   assign next_irq_stat = (stat_rd ? '0 : irq_stat) | irq_set;

   // Status register; events are edges, not levels, so a trigger
   // that stays true raises one interrupt, not a stream
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   // Mask, written whole; data bits above the status width drop
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_mask <= IW'(uart_fifo_pkg::MASK_RESET);
      end else if (mask_wr) begin
         irq_mask <= req.dat[IW-1:0];
      end
   end

   // Registered so the line is glitch free; lags status by one cycle
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_stat & irq_mask);
      end
   end

   // ============================================================
   // Read data decode; threshold registers are write-only and read
   // as zero, as does any unmapped address. The view at 0x48 lets
   // software poll trigger levels without touching the status
   always_comb begin
      next_rdata = '0;
      if (req.adr == uart_fifo_pkg::REG_IRQ_STAT) begin
         next_rdata = DW'(irq_stat);
      end else if (req.adr == uart_fifo_pkg::REG_IRQ_MASK) begin
         next_rdata = DW'(irq_mask);
      end else if (req.adr == uart_fifo_pkg::REG_TRIG_VIEW) begin
         next_rdata = DW'({rx_trigger_out, tx_trigger_out});
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (req.adr == 8'(i * 32'(uart_fifo_pkg::CH_STRIDE)) +
                           uart_fifo_pkg::REG_TX_OCC) begin
               next_rdata = DW'(tx_occ[i]); // [R1]
            end else if (req.adr == 8'(i * 32'(uart_fifo_pkg::CH_STRIDE)) +
                                    uart_fifo_pkg::REG_RX_OCC) begin
               next_rdata = DW'(rx_occ[i]); // [R4]
            end else if (req.adr == 8'(i * 32'(uart_fifo_pkg::CH_STRIDE)) +
                                    uart_fifo_pkg::REG_MODEM) begin
               next_rdata = DW'(modem[i]); // [R7]
            end
         end
      end
   end

   // Read data is captured when the request is taken, so it stands
   // through the ack cycle, and is held until the next read
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wb_dat_out <= '0;
      end else if (rd_access) begin
         wb_dat_out <= next_rdata;
      end
   end

endmodule

// ---- src/uart_fifo_pkg.sv ----
// Shared constants and carrier types for the FIFO level and trigger block
// ============================================================
// Summary of operation
// R1 - Read transmit FIFO character count, 0 to 64
// R2 - Write transmit trigger level, 0 to 64
// R3 - Transmit request when count below trigger level
// R4 - Read receive FIFO character count, 0 to 64
// R5 - Write receive trigger level, 0 to 64
// R6 - Receive request when count reaches trigger level
// R7 - Reset clears change bits, loads modem levels; here levels reset to zero and are caught from the pins after release
// R8 - Counts follow entries and exits, zero after reset
// ============================================================
package uart_fifo_pkg;

   // ============================================================
   // Widths and sizes
   localparam int DATA_W     = 32;
   localparam int ADDR_W     = 8;
   localparam int SEL_W      = 4;
   localparam int LEVEL_W    = 8;
   localparam int MODEM_W    = 4;
   localparam int FIFO_DEPTH = 64;

   // ============================================================
   // Register offsets, per channel relative to the channel base, then the channel stride and the absolute shared addresses
   localparam logic [7:0] REG_TX_OCC    = 8'h00;
   localparam logic [7:0] REG_TX_THR    = 8'h04;
   localparam logic [7:0] REG_RX_OCC    = 8'h08;
   localparam logic [7:0] REG_RX_THR    = 8'h0c;
   localparam logic [7:0] REG_MODEM     = 8'h10;
   localparam logic [7:0] CH_STRIDE     = 8'h20;
   localparam logic [7:0] REG_IRQ_STAT  = 8'h40;
   localparam logic [7:0] REG_IRQ_MASK  = 8'h44;
   localparam logic [7:0] REG_TRIG_VIEW = 8'h48;

   // ============================================================
   // Reset values and field layout
   localparam logic [7:0] LEVEL_RESET   = 8'h00;
   localparam logic [7:0] MASK_RESET    = 8'h00;
   localparam logic [3:0] DELTA_RESET   = 4'h0;
   localparam int IRQ_TX_BIT    = 0;
   localparam int IRQ_RX_BIT    = 1;
   localparam int IRQ_MODEM_BIT = 2;
   localparam int IRQ_PER_CH    = 3;

   // ============================================================
   // Carrier types
   typedef struct packed {
      logic push;
      logic pop;
   } fifo_move_t;

   typedef struct packed {
      logic               cyc;
      logic               stb;
      logic               we;
      logic [ADDR_W-1:0]  adr;
      logic [SEL_W-1:0]   sel;
      logic [DATA_W-1:0]  dat;
   } wb_req_t;

endpackage

// ---- verification/fifo_trigger_checker.sv ----
// Port-level checks for the FIFO level and trigger block
`timescale 1ns/1ps
module fifo_trigger_checker #(
   parameter int NUM_CH = 2,
   parameter int DEPTH  = 64
) (
   // Clock and reset
   input wire logic                clk_in,
   input wire logic                resetn_in,
   // Bus
   input wire logic                wb_cyc_in,
   input wire logic                wb_stb_in,
   input wire logic                wb_we_in,
   input wire logic [7:0]          wb_adr_in,
   input wire logic [3:0]          wb_sel_in,
   input wire logic [31:0]         wb_dat_in,
   input wire logic [31:0]         wb_dat_out,
   input wire logic                wb_ack_out,
   // Moves, modem pins, results
   input wire logic [NUM_CH-1:0]   tx_push_in,
   input wire logic [NUM_CH-1:0]   tx_pop_in,
   input wire logic [NUM_CH-1:0]   rx_push_in,
   input wire logic [NUM_CH-1:0]   rx_pop_in,
   input wire logic [4*NUM_CH-1:0] modem_in,
   input wire logic [NUM_CH-1:0]   tx_trigger_out,
   input wire logic [NUM_CH-1:0]   rx_trigger_out,
   input wire logic                irq_out
);
   // ====
   // Reference of channel 0
   logic [7:0] tx_cnt, rx_cnt, tx_thr, rx_thr;
   logic       wr_ok, tx_low, rx_hit, tx_low_q, rx_hit_q;
   assign wr_ok  = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out
                   && wb_sel_in[0];
   assign tx_low = tx_cnt < tx_thr;
   assign rx_hit = rx_cnt >= rx_thr;
   // Saturating, since a full FIFO drops a push
   function automatic logic [7:0] step(logic [7:0] c, logic up, logic dn);
      if (up && !dn && c < DEPTH) return c + 8'h01;
      if (dn && !up && c != 8'h00) return c - 8'h01;
      return c;
   endfunction
   // Counts follow the strobes
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_cnt <= 8'h00;
         rx_cnt <= 8'h00;
      end else begin
         tx_cnt <= step(tx_cnt, tx_push_in[0], tx_pop_in[0]);
         rx_cnt <= step(rx_cnt, rx_push_in[0], rx_pop_in[0]);
      end
   end
   // Levels take effect at the acknowledged write
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_thr <= 8'h00;
         rx_thr <= 8'h00;
      end else if (wr_ok) begin
         if (wb_adr_in == 8'h04) tx_thr <= wb_dat_in[7:0];
         if (wb_adr_in == 8'h0c) rx_thr <= wb_dat_in[7:0];
      end
   end
   // Triggers are registered, so they follow one edge behind
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_low_q <= 1'b0;
         rx_hit_q <= 1'b0;
      end else begin
         tx_low_q <= tx_low;
         rx_hit_q <= rx_hit;
      end
   end
   // ====
   // Assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_req;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence s_rd(logic [7:0] a);
      s_req ##0 !wb_we_in && wb_adr_in == a;
   endsequence
   property p_ack_resp; s_req |=> wb_ack_out; endproperty
   property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
   property p_tx_trig; tx_trigger_out[0] == tx_low_q; endproperty
   property p_rx_trig; rx_trigger_out[0] == rx_hit_q; endproperty
   property p_tx_thr; s_rd(8'h04) |=> wb_dat_out == 32'h0; endproperty
   property p_rx_thr; s_rd(8'h0c) |=> wb_dat_out == 32'h0; endproperty
   property p_tx_occ;
      s_rd(8'h00) |=> wb_dat_out == {24'h0, $past(tx_cnt)};
   endproperty
   property p_rx_occ;
      s_rd(8'h08) |=> wb_dat_out == {24'h0, $past(rx_cnt)};
   endproperty
   a_ack_resp: assert property (p_ack_resp)
      else $error("request not acknowledged next cycle");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   a_tx_trig: assert property (p_tx_trig)
      else $error("tx trigger level wrong");
   a_rx_trig: assert property (p_rx_trig)
      else $error("rx trigger level wrong");
   a_tx_thr: assert property (p_tx_thr)
      else $error("tx level readable");
   a_rx_thr: assert property (p_rx_thr)
      else $error("rx level readable");
   a_tx_occ: assert property (p_tx_occ)
      else $error("tx count read wrong");
   a_rx_occ: assert property (p_rx_occ)
      else $error("rx count read wrong");
endmodule

bind uart_fifo_level_trigger fifo_trigger_checker #(
   .NUM_CH(NUM_CH), .DEPTH(DEPTH)) i_chk (
   .clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .tx_push_in(tx_push_in), .tx_pop_in(tx_pop_in),
   .rx_push_in(rx_push_in), .rx_pop_in(rx_pop_in), .modem_in(modem_in),
   .tx_trigger_out(tx_trigger_out), .rx_trigger_out(rx_trigger_out),
   .irq_out(irq_out));

// ---- verification/testbench.sv ----
// Self-checking bench for the FIFO level and trigger block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
   logic        clk_in, resetn_in, cyc, stb, we, ack, irq;
   logic [7:0]  adr, modem;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   logic [1:0]  txu, txd, rxu, rxd, tx_trig, rx_trig;
   int          fails, checked;

   uart_fifo_level_trigger #(.NUM_CH(2), .DEPTH(64)) i_dut (
      .clk_in(clk_in), .resetn_in(resetn_in), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .tx_push_in(txu), .tx_pop_in(txd), .rx_push_in(rxu),
      .rx_pop_in(rxd), .modem_in(modem), .tx_trigger_out(tx_trig),
      .rx_trigger_out(rx_trig), .irq_out(irq));
   uart_core_model #(.NUM_CH(2)) i_core (
      .clk_in(clk_in), .tx_push_out(txu), .tx_pop_out(txd),
      .rx_push_out(rxu), .rx_pop_out(rxd));

   // ====
   // Clock and bus tasks
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // One classic cycle; ack is sampled before the edge updates land
   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= d;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk_in);
      end while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(a, 1'b0, 32'h0, r);
      `CHK(r, e)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(a, 1'b1, d, r);
   endtask
   // Triggers lag the counts by one register, irq by two
   task automatic settle;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      repeat (5000) @(posedge clk_in);
      fails++;
      stop_test;
   end

   // ====
   // Tests
   initial begin
      {cyc, stb, we, adr, wdat, fails, checked} = '0;
      sel = 4'hf;
      modem = 8'h0a;
      resetn_in = 1'b0;
      repeat (3) @(posedge clk_in);
      resetn_in <= 1'b1;
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h08, 32'h0);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h0c, 32'h0);
      rd_chk(8'h80, 32'h0);
      rd_chk(8'h10, 32'ha0);
      rd_chk(8'h30, 32'h0);
      modem <= 8'h05;
      settle;
      rd_chk(8'h10, 32'h5f);
      rd_chk(8'h10, 32'h50);
      $display("test reset and modem done");
      wr(8'h04, 32'h03);
      i_core.move(0, 0, 2);
      settle;
      `CHK(tx_trig[0], 1'b1)
      i_core.move(0, 0, 1);
      settle;
      `CHK(tx_trig[0], 1'b0)
      i_core.move(0, 0, 62);
      rd_chk(8'h00, 32'h40);
      i_core.move(1, 0, 65);
      rd_chk(8'h00, 32'h0);
      i_core.move(0, 1, 5);
      rd_chk(8'h20, 32'h5);
      $display("test transmit done");
      wr(8'h0c, 32'h40);
      i_core.move(2, 0, 63);
      settle;
      `CHK(rx_trig[0], 1'b0)
      i_core.move(2, 0, 1);
      settle;
      `CHK(rx_trig[0], 1'b1)
      rd_chk(8'h08, 32'h40);
      i_core.move(3, 0, 64);
      rd_chk(8'h08, 32'h0);
      $display("test receive done");
      wr(8'h0c, 32'h0);
      wr(8'h04, 32'h0);
      settle;
      wb(8'h40, 1'b0, 32'h0, q);
      rd_chk(8'h40, 32'h0);
      wr(8'h44, 32'h01);
      wr(8'h04, 32'h01);
      settle;
      `CHK(irq, 1'b1)
      wr(8'h44, 32'h0);
      settle;
      `CHK(irq, 1'b0)
      wr(8'h44, 32'h01);
      settle;
      `CHK(irq, 1'b1)
      rd_chk(8'h40, 32'h1);
      settle;
      `CHK(irq, 1'b0)
      rd_chk(8'h40, 32'h0);
      rd_chk(8'h48, 32'hd);
      $display("test interrupt done");
      stop_test;
   end
endmodule

// ---- verification/uart_core_model.sv ----
// Stand-in for the UART cores that move characters through the FIFOs
`timescale 1ns/1ps
module uart_core_model #(
   parameter int NUM_CH = 2
) (
   // Clock
   input  wire logic         clk_in,
   // Character strobes
   output logic [NUM_CH-1:0] tx_push_out,
   output logic [NUM_CH-1:0] tx_pop_out,
   output logic [NUM_CH-1:0] rx_push_out,
   output logic [NUM_CH-1:0] rx_pop_out
);
   logic [4*NUM_CH-1:0] strobes = '0;
   assign {rx_pop_out, rx_push_out, tx_pop_out, tx_push_out} = strobes;
   // Kind 0 tx push, 1 tx pop, 2 rx push, 3 rx pop; back to back
   task automatic move(input int kind, input int ch, input int n);
      logic [4*NUM_CH-1:0] one;
      one = '0;
      one[kind*NUM_CH+ch] = 1'b1;
      repeat (n) begin
         @(posedge clk_in);
         strobes <= one;
      end
      @(posedge clk_in);
      strobes <= '0;
   endtask
endmodule
